// ---- aotr_pkg.sv ----
// Package for the converter offset and gain trim register bank.
// Assumes a 32-bit APB slave; offsets are not byte addresses as printed (some not multiples of four,
// so every printed offset is an index, byte address = 4 * index).
package aotr_pkg;

  // ------------------------------------------------------------
  // Register indices and geometry
  // ------------------------------------------------------------
  localparam int unsigned NUM_OFS = 7;
  localparam int unsigned ADDR_W  = 12;
  localparam logic [11:0] IDX_TRIM_C1  = 12'h332;
  localparam logic [11:0] IDX_TRIM_C2A = 12'h334;
  localparam logic [11:0] IDX_TRIM_C2B = 12'h336;
  localparam logic [11:0] IDX_TRIM_C3C = 12'h338;
  localparam logic [11:0] IDX_TRIM_C3D = 12'h33a;
  localparam logic [11:0] IDX_TRIM_C4  = 12'h33c;
  localparam logic [11:0] IDX_TRIM_C5  = 12'h33e;
  localparam logic [11:0] IDX_FINE_GAIN = 12'h360;
  localparam logic [11:0] IDX_FUSE_CTRL = 12'h370;

  // ------------------------------------------------------------
  // Field layouts and reset values
  // ------------------------------------------------------------
  localparam int unsigned OFS_REG_W  = 16;
  localparam int unsigned OFS_VAL_W  = 12;
  localparam int unsigned GAIN_REG_W = 8;
  localparam logic [15:0] OFS_RESET  = 16'h0000;
  localparam logic [7:0]  GAIN_RESET = 8'h00;
  localparam int unsigned FUSE_W     = NUM_OFS * OFS_REG_W + GAIN_REG_W;
  localparam int unsigned FUSE_LOAD_CYCLES = 4;
  localparam int unsigned FUSE_BUSY_BIT    = 0;
  localparam int unsigned FUSE_RELOAD_BIT  = 1;

  // Core input selection
  typedef struct packed {
    logic core2InputB;
    logic core3InputD;
  } aotr_insel_t;

  // Trims applied to the cores
  typedef struct packed {
    logic [11:0] core1;
    logic [11:0] core2;
    logic [11:0] core3;
    logic [11:0] core4;
    logic [11:0] core5;
    logic [7:0]  fine_gain_trim_core0;
  } aotr_trim_t;

endpackage : aotr_pkg

// ---- aotr_fuse_loader.sv ----
// Fuse loader: loads factory trims after reset or on request.
// Assumes fuse word is static, from a fuse macro in the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none
module aotr_fuse_loader (
  input  wire logic                       sys_clk,  // Clock
  input  wire logic                       rst_n,    // Async reset, active low
  input  wire logic                       reloadReq, // Pulse to reload fuses
  output logic                            loadStb,  // One-cycle load strobe
  output logic                            busy      // Load in progress
);
  typedef enum logic [1:0] {AOTR_IDLE, AOTR_WAIT, AOTR_LOAD} aotr_fstate_t;
  aotr_fstate_t stateQ;
  logic [2:0]   cntQ;
  wire          cntDone = (cntQ == 3'(aotr_pkg::FUSE_LOAD_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ  <= AOTR_WAIT;
      cntQ    <= 3'h0;
      loadStb <= 1'b0;
      busy    <= 1'b1;
    end else begin
      loadStb <= 1'b0;
      case (stateQ)
        AOTR_IDLE: begin
          busy <= reloadReq;
          cntQ <= 3'h0;
          if (reloadReq) begin
            stateQ <= AOTR_WAIT;
          end
        end
        AOTR_WAIT: begin
          cntQ <= cntQ + 3'h1;
          if (cntDone) begin
            stateQ <= AOTR_LOAD;
          end
        end
        default: begin
          loadStb <= 1'b1;
          busy    <= 1'b0;
          stateQ  <= AOTR_IDLE;
        end
      endcase
    end
  end
endmodule : aotr_fuse_loader
`default_nettype wire

// ---- aotr_trim_regs.sv ----
// Offset and fine-gain trim register bank with APB slave.
// Assumes APB master on sys_clk; fuse word and input selects are synchronous to sys_clk.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module aotr_trim_regs (
  input  wire logic                              sys_clk,     // 250 MHz clock
  input  wire logic                              rst_n,       // Async reset, active low
  input  wire logic [31:0]                       paddr,       // APB address
  input  wire logic                              psel,        // APB select
  input  wire logic                              penable,     // APB enable
  input  wire logic                              pwrite,      // APB direction
  input  wire logic [31:0]                       pwdata,      // APB write data
  input  wire logic [3:0]                        pstrb,       // APB byte strobes
  output logic      [31:0]                       prdata,      // APB read data
  output logic                                   pready,      // APB ready
  output logic                                   pslverr,     // APB error
  input  wire logic [aotr_pkg::FUSE_W-1:0]       fuseWord,    // Factory trims
  input  wire aotr_pkg::aotr_insel_t             inputSel,    // Active inputs
  output aotr_pkg::aotr_trim_t                   trimOut      // Applied trims
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [15:0] ofsQ [aotr_pkg::NUM_OFS];
  logic [7:0]  gainQ;
  logic        reloadQ;
  logic        loadStb;
  logic        fuseBusy;

  aotr_fuse_loader u_loader (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .reloadReq (reloadQ),
    .loadStb   (loadStb),
    .busy      (fuseBusy)
  );

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire        wordAligned = (paddr[1:0] == 2'h0) && (paddr[31:14] == 18'h0);
  wire [11:0] idx         = paddr[13:2];
  wire        access      = psel && penable;
  wire        wrAcc       = access && pwrite;
  wire        hitGain     = wordAligned && (idx == aotr_pkg::IDX_FINE_GAIN);
  wire        hitCtrl     = wordAligned && (idx == aotr_pkg::IDX_FUSE_CTRL);
  logic [aotr_pkg::NUM_OFS-1:0] hitOfs;
  logic [11:0] ofsIdx [aotr_pkg::NUM_OFS];
  assign ofsIdx[0] = aotr_pkg::IDX_TRIM_C1;
  assign ofsIdx[1] = aotr_pkg::IDX_TRIM_C2A;
  assign ofsIdx[2] = aotr_pkg::IDX_TRIM_C2B;
  assign ofsIdx[3] = aotr_pkg::IDX_TRIM_C3C;
  assign ofsIdx[4] = aotr_pkg::IDX_TRIM_C3D;
  assign ofsIdx[5] = aotr_pkg::IDX_TRIM_C4;
  assign ofsIdx[6] = aotr_pkg::IDX_TRIM_C5;
  wire        hitAny      = (|hitOfs) || hitGain || hitCtrl;

  // ------------------------------------------------------------
  // Offset registers
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < aotr_pkg::NUM_OFS; gi++) begin : g_ofs
      assign hitOfs[gi] = wordAligned && (idx == ofsIdx[gi]);
      wire [15:0] fuseVal = fuseWord[gi*16 +: 16];
      wire [15:0] wrVal   = {pstrb[1] ? pwdata[15:8] : ofsQ[gi][15:8],
                             pstrb[0] ? pwdata[7:0]  : ofsQ[gi][7:0]};
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ofsQ[gi] <= aotr_pkg::OFS_RESET;
        end else if (loadStb) begin
          ofsQ[gi] <= fuseVal;
        end else if (wrAcc && hitOfs[gi]) begin
          ofsQ[gi] <= wrVal;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Gain and control
  // ------------------------------------------------------------
  wire [7:0] gainFuse = fuseWord[aotr_pkg::NUM_OFS*16 +: 8];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gainQ <= aotr_pkg::GAIN_RESET;
    end else if (loadStb) begin
      gainQ <= gainFuse;
    end else if (wrAcc && hitGain && pstrb[0]) begin
      gainQ <= pwdata[7:0];
    end
  end

  wire reloadD = wrAcc && hitCtrl && pstrb[0] && pwdata[aotr_pkg::FUSE_RELOAD_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reloadQ <= 1'b0;
    end else begin
      reloadQ <= reloadD && !fuseBusy;
    end
  end

  // ------------------------------------------------------------
  // Read mux and APB response
  // ------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    for (int i = 0; i < aotr_pkg::NUM_OFS; i++) begin
      if (hitOfs[i]) begin
        rdMux = {16'h0, ofsQ[i]};
      end
    end
    if (hitGain) begin
      rdMux = {24'h0, gainQ};
    end else if (hitCtrl) begin
      rdMux = {31'h0, fuseBusy};
    end
  end

  // Zero-wait answer: pready high in the access phase itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hitAny;
      prdata  <= (psel && !penable && !pwrite) ? rdMux : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Applied trims
  // ------------------------------------------------------------
  wire [11:0] core2Sel = inputSel.core2InputB ? ofsQ[2][11:0] : ofsQ[1][11:0];
  wire [11:0] core3Sel = inputSel.core3InputD ? ofsQ[4][11:0] : ofsQ[3][11:0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trimOut <= '0;
    end else begin
      trimOut.core1 <= ofsQ[0][11:0];
      trimOut.core2 <= core2Sel;
      trimOut.core3 <= core3Sel;
      trimOut.core4 <= ofsQ[5][11:0];
      trimOut.core5 <= ofsQ[6][11:0];
      trimOut.fine_gain_trim_core0 <= gainQ;
    end
  end

endmodule : aotr_trim_regs
`default_nettype wire

// ---- aotr_trim_regs_sva.sv ----
// Checker for the trim bank: APB answer timing and trim updates after writes.
// Assumes it is bound to aotr_trim_regs and that input selects stay put around writes.
`timescale 1ns/10ps
`default_nettype none
module aotr_trim_regs_chk (
  input wire logic                  sys_clk,  // Clock
  input wire logic                  rst_n,    // Reset, active low
  input wire logic [31:0]           paddr,    // Address
  input wire logic                  psel,     // Select
  input wire logic                  penable,  // Enable
  input wire logic                  pwrite,   // Direction
  input wire logic [31:0]           pwdata,   // Write data
  input wire logic [3:0]            pstrb,    // Strobes
  input wire logic [31:0]           prdata,   // Read data
  input wire logic                  pready,   // Ready
  input wire logic                  pslverr,  // Error
  input wire aotr_pkg::aotr_insel_t inputSel, // Active inputs
  input wire aotr_pkg::aotr_trim_t  trimOut   // Applied trims
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A completed full write reaches the chosen trim two edges later
  property p_wr(logic [31:0] a, logic en, logic [11:0] got, logic [11:0] v);
    pready && pwrite && !pslverr && pstrb == 4'hf && paddr == a && en |-> ##2 got == v;
  endproperty
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  a_core1_wr: assert property (p_wr(32'hcc8, 1'b1, trimOut.core1,
    $past(pwdata[11:0], 2))) else $error("core1 trim");
  a_core2_ina: assert property (p_wr(32'hcd0, !inputSel.core2InputB, trimOut.core2,
    $past(pwdata[11:0], 2))) else $error("core2 input a trim");
  a_core2_inb: assert property (p_wr(32'hcd8, inputSel.core2InputB, trimOut.core2,
    $past(pwdata[11:0], 2))) else $error("core2 input b trim");
  a_core3_inc: assert property (p_wr(32'hce0, !inputSel.core3InputD, trimOut.core3,
    $past(pwdata[11:0], 2))) else $error("core3 input c trim");
  a_core3_ind: assert property (p_wr(32'hce8, inputSel.core3InputD, trimOut.core3,
    $past(pwdata[11:0], 2))) else $error("core3 input d trim");
  a_core4_wr: assert property (p_wr(32'hcf0, 1'b1, trimOut.core4,
    $past(pwdata[11:0], 2))) else $error("core4 trim");
  a_core5_wr: assert property (p_wr(32'hcf8, 1'b1, trimOut.core5,
    $past(pwdata[11:0], 2))) else $error("core5 trim");
  a_gain_wr: assert property (p_wr(32'hd80, 1'b1, {4'h0, trimOut.fine_gain_trim_core0},
    {4'h0, $past(pwdata[7:0], 2)})) else $error("gain trim");
  c_err: cover property (pslverr);
  c_write: cover property (pready && pwrite);
  c_read: cover property (pready && !pwrite);
endmodule : aotr_trim_regs_chk
`default_nettype wire

// ---- adc_offset_gain_trim_regs_test.sv ----
// Self-checking bench for the trim bank, driving APB, fuses and input selects.
// Assumes the checker module is compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module adc_offset_gain_trim_regs_test;
  logic                        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [31:0]                 paddr = 0, pwdata = 0, prdata, rd;
  logic [3:0]                  pstrb = 4'hf;
  logic                        pready, pslverr;
  logic [aotr_pkg::FUSE_W-1:0] fuseWord;
  aotr_pkg::aotr_insel_t       inputSel = '0;
  aotr_pkg::aotr_trim_t        trimOut, expT;
  logic [15:0]                 val [8];
  logic [20:0]                 rows [8] = '{{3'd0, 2'd0, 16'h0abc}, {3'd1, 2'd0, 16'h0fff},
    {3'd2, 2'd3, 16'h0001}, {3'd3, 2'd0, 16'h0800}, {3'd4, 2'd3, 16'h0123},
    {3'd5, 2'd0, 16'hf456}, {3'd6, 2'd0, 16'h0000}, {3'd7, 2'd0, 16'h00a5}};
  int                          num_errors = 0, cmp_count = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  aotr_trim_regs dut_u (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .fuseWord, .inputSel, .trimOut);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] ra(int i);
    return i < 7 ? 32'hcc8 + 32'(8 * i) : 32'hd80;
  endfunction : ra
  task automatic final_report;
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk(input logic [67:0] got, input logic [67:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic check_trim;
    repeat (3) @(posedge sys_clk);
    expT.core1 = val[0][11:0];
    expT.core2 = inputSel.core2InputB ? val[2][11:0] : val[1][11:0];
    expT.core3 = inputSel.core3InputD ? val[4][11:0] : val[3][11:0];
    expT.core4 = val[5][11:0];
    expT.core5 = val[6][11:0];
    expT.fine_gain_trim_core0 = val[7][7:0];
    chk(trimOut, expT);
  endtask : check_trim
  task automatic fuse_values;
    for (int i = 0; i < 8; i++) val[i] = i < 7 ? fuseWord[16*i+:16] : {8'h0, fuseWord[119:112]};
  endtask : fuse_values
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 7; i++) fuseWord[16*i+:16] = 16'h0a10 + 16'(i);
    fuseWord[119:112] = 8'h5c;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    fuse_values();
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ra(i), 32'h0);
      chk(rd, val[i]);
    end
    check_trim();
    // Reserved bits 31:16 are set in every write; bits 15:12 are set only in the sixth row
    for (int r = 0; r < 8; r++) begin
      inputSel <= rows[r][17:16];
      val[rows[r][20:18]] = rows[r][20:18] == 3'd7 ? rows[r][15:0] & 16'h00ff : rows[r][15:0];
      apb(1'b1, ra(rows[r][20:18]), {16'hffff, rows[r][15:0]});
      apb(1'b0, ra(rows[r][20:18]), 32'h0);
      chk(rd, val[rows[r][20:18]]);
    end
    for (int s = 0; s < 4; s++) begin
      inputSel <= 2'(s);
      check_trim();
    end
    apb(1'b0, 32'h004, 32'h0);
    chk({rd, er}, {32'h0, 1'b1});
    apb(1'b1, 32'h004, 32'hffff);
    chk(er, 1'b1);
    check_trim(); // the two erroring accesses to 0x004 leave every trim unchanged
    apb(1'b1, 32'hdc0, 32'h2);
    repeat (10) @(posedge sys_clk);
    fuse_values();
    check_trim();
    final_report();
  end
endmodule : adc_offset_gain_trim_regs_test
bind aotr_trim_regs aotr_trim_regs_chk u_chk (.sys_clk, .rst_n, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .inputSel, .trimOut);
`default_nettype wire
